// >>> hw/sapd_pkg.sv
package sapd_pkg;

    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned RES_W = 10;
    localparam int unsigned BYTE_W = 8;

    localparam int unsigned CLK_MHZ = CLK_HZ / 1000000;
    localparam int unsigned NS_PER_US = 1000;
    // internal power-up pulse after each rising edge of convert start, rounded up
    localparam int unsigned PWRUP_NS = 1500;
    localparam int unsigned PWRUP_CYC = (PWRUP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    // conversion time paced by the internal oscillator; integer math avoids real rounding
    localparam int unsigned CONV_NS = 2300;
    localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ) / NS_PER_US;
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] PWRUP_LOAD = CNT_W'(PWRUP_CYC);
    localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYC);

    localparam logic [RES_W-1:0] RES_RESET = 10'h000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam int unsigned MSB_LO = 2;
    localparam logic [5:0] LSB_PAD = 6'h00;

    typedef enum logic [1:0] {
        SAPD_OFF,
        SAPD_ON,
        SAPD_CONV
    } sapd_state_t;

    // analog side of the converter core
    typedef struct packed {
        logic input_select_switch;
        logic comparator_balance_switch;
        logic powered;
    } sapd_analog_t;

    // read port strobes, already synchronised
    typedef struct packed {
        logic rd;
        logic cs;
    } sapd_rd_t;

endpackage : sapd_pkg

// >>> hw/sapd_sync.sv
`timescale 1ns/100ps
module sapd_sync (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_sync
);
    logic meta;
    logic next_meta;
    logic next_sync;

    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule : sapd_sync

// >>> hw/sapd_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - busy rises when a conversion starts and falls when it ends.
// - the conversion ends when the comparator reports balance or the internal timebase runs out, then the code is produced.
// - after reset the block is powered down and cannot convert until powered up.
// - power-up is entered on the rising edge of the internal pulse and lasts 1.5 us.
// - each rising edge of convert start fires a 1.5 us internal pulse.
// - conversion starts on the falling edge of the gated start, not the pin alone.
// - in automatic power-down the block powers down after each conversion.
// - the 10-bit result is straight binary, one step being the reference over 1024.
// - the gated start is the OR of the pin level and the internal pulse.
// - the pin level when busy falls selects staying powered or powering down.
// - the result is read as two bytes: 8 MSBs, then 2 LSBs on the top lines.
module sapd_ctrl (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_convert_start_n,
    input wire logic i_comp_balanced,
    input wire logic [sapd_pkg::RES_W-1:0] i_sar_code,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    output logic o_busy,
    output sapd_pkg::sapd_analog_t o_analog,
    output logic [sapd_pkg::BYTE_W-1:0] o_result_byte_lines,
    output logic o_result_byte_lines_oe
);
    logic cs_s;
    logic rd_s;
    logic cvs_s;
    logic cs_n_s;
    logic rd_n_s;

    // pins cross into the core clock before any logic sees them
    sapd_sync u_sync_cvs (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_convert_start_n),
        .o_sync(cvs_s)
    );
    sapd_sync u_sync_cs (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(~i_cs_n),
        .o_sync(cs_s)
    );
    sapd_sync u_sync_rd (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(~i_rd_n),
        .o_sync(rd_s)
    );
    assign cs_n_s = ~cs_s;
    assign rd_n_s = ~rd_s;

    sapd_pkg::sapd_rd_t rd_now;
    assign rd_now = '{rd: ~rd_n_s, cs: ~cs_n_s};

    sapd_pkg::sapd_state_t state;
    sapd_pkg::sapd_state_t next_state;
    logic cvs_d;
    logic next_cvs_d;
    logic gated_d;
    logic next_gated_d;
    logic pulse;
    logic next_pulse;
    logic [sapd_pkg::CNT_W-1:0] pcnt;
    logic [sapd_pkg::CNT_W-1:0] next_pcnt;
    logic [sapd_pkg::CNT_W-1:0] ccnt;
    logic [sapd_pkg::CNT_W-1:0] next_ccnt;
    logic busy;
    logic next_busy;
    logic [sapd_pkg::RES_W-1:0] result;
    logic [sapd_pkg::RES_W-1:0] next_result;
    logic gated;
    logic cvs_rise;
    logic gated_fall;
    logic conv_done;

    assign gated = cvs_s | pulse;
    assign cvs_rise = cvs_s & ~cvs_d;
    assign gated_fall = gated_d & ~gated;
    // balance reported by the comparator or the internal timebase running out
    assign conv_done = (ccnt == sapd_pkg::CNT_ONE) || i_comp_balanced;

    always_comb begin
        next_cvs_d = cvs_s;
        next_gated_d = gated;
        next_pulse = pulse;
        next_pcnt = pcnt;
        next_ccnt = ccnt;
        next_busy = busy;
        next_result = result;
        next_state = state;
        if (cvs_rise) begin
            next_pulse = 1'b1;
            next_pcnt = sapd_pkg::PWRUP_LOAD;
        end else if (pcnt != sapd_pkg::CNT_ZERO) begin
            next_pcnt = pcnt - sapd_pkg::CNT_ONE;
            if (pcnt == sapd_pkg::CNT_ONE) begin
                next_pulse = 1'b0;
            end
        end
        case (state)
            sapd_pkg::SAPD_OFF: begin
                // only the pulse leaves power-down; a fall while off is ignored
                if (cvs_rise) begin
                    next_state = sapd_pkg::SAPD_ON;
                end
            end
            sapd_pkg::SAPD_ON: begin
                if (gated_fall) begin
                    next_state = sapd_pkg::SAPD_CONV;
                    next_busy = 1'b1;
                    next_ccnt = sapd_pkg::CONV_LOAD;
                end
            end
            sapd_pkg::SAPD_CONV: begin
                next_ccnt = ccnt - sapd_pkg::CNT_ONE;
                if (conv_done) begin
                    next_busy = 1'b0;
                    next_ccnt = sapd_pkg::CNT_ZERO;
                    next_result = i_sar_code;
                    // pin high at end keeps power, low powers down
                    next_state = cvs_s ? sapd_pkg::SAPD_ON : sapd_pkg::SAPD_OFF;
                end
            end
            default: begin
                next_state = sapd_pkg::SAPD_OFF;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= sapd_pkg::SAPD_OFF;
            cvs_d <= 1'b0;
            gated_d <= 1'b0;
            pulse <= 1'b0;
            pcnt <= sapd_pkg::CNT_ZERO;
            ccnt <= sapd_pkg::CNT_ZERO;
            busy <= 1'b0;
            result <= sapd_pkg::RES_RESET;
        end else begin
            state <= next_state;
            cvs_d <= next_cvs_d;
            gated_d <= next_gated_d;
            pulse <= next_pulse;
            pcnt <= next_pcnt;
            ccnt <= next_ccnt;
            busy <= next_busy;
            result <= next_result;
        end
    end

    // read port: first read gives the MSBs, second the LSBs, repeating
    logic second;
    logic next_second;
    logic rd_d;
    logic next_rd_d;
    logic [sapd_pkg::BYTE_W-1:0] dout;
    logic [sapd_pkg::BYTE_W-1:0] next_dout;
    logic dout_oe;
    logic next_dout_oe;
    sapd_pkg::sapd_analog_t analog;
    sapd_pkg::sapd_analog_t next_analog;

    always_comb begin
        next_rd_d = rd_now.cs & rd_now.rd;
        next_second = second;
        next_dout_oe = rd_now.cs & rd_now.rd;
        if (busy) begin
            next_second = 1'b0; // port resets while converting
        end else if (rd_d && !(rd_now.cs & rd_now.rd)) begin
            next_second = ~second;
        end
        if (second) begin
            next_dout = {result[sapd_pkg::MSB_LO-1:0], sapd_pkg::LSB_PAD};
        end else begin
            next_dout = result[sapd_pkg::RES_W-1:sapd_pkg::MSB_LO];
        end
        next_analog.powered = (next_state != sapd_pkg::SAPD_OFF);
        next_analog.input_select_switch = (next_state == sapd_pkg::SAPD_CONV);
        next_analog.comparator_balance_switch = (next_state != sapd_pkg::SAPD_CONV);
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            second <= 1'b0;
            rd_d <= 1'b0;
            dout <= sapd_pkg::BYTE_RESET;
            dout_oe <= 1'b0;
            analog <= '0;
        end else begin
            second <= next_second;
            rd_d <= next_rd_d;
            dout <= next_dout;
            dout_oe <= next_dout_oe;
            analog <= next_analog;
        end
    end

    assign o_busy = busy;
    assign o_analog = analog;
    assign o_result_byte_lines = dout;
    assign o_result_byte_lines_oe = dout_oe;
endmodule : sapd_ctrl

// >>> testbench/sapd_ctrl_properties.sv
`timescale 1ns/100ps
module sapd_ctrl_chk (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_convert_start_n,
    input wire logic i_comp_balanced,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic o_busy,
    input wire sapd_pkg::sapd_analog_t o_analog,
    input wire logic o_result_byte_lines_oe
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_pwr; $rose(o_busy) |-> o_analog.powered && $past(o_analog.powered, 28); endproperty
    a_pwr: assert property (p_pwr) else $error("busy before power-up");
    property p_len; $rose(o_busy) |-> ##[1:48] !o_busy; endproperty
    a_len: assert property (p_len) else $error("conversion too long");
    property p_bal; o_busy && i_comp_balanced |-> ##[1:4] !o_busy; endproperty
    a_bal: assert property (p_bal) else $error("balance did not end conversion");
    // the pin reaches busy through two sync flops and the busy register
    property p_pin; $rose(o_busy) |-> !$past(i_convert_start_n, 3); endproperty
    a_pin: assert property (p_pin) else $error("conversion while pin high");
    property p_sw;
        $rose(o_busy) |-> ##[0:1] (o_analog.input_select_switch &&
            !o_analog.comparator_balance_switch);
    endproperty
    a_sw: assert property (p_sw) else $error("switches not in hold");
    property p_off;
        (!i_convert_start_n)[*6] ##1 $fell(o_busy) |-> ##[0:3] !o_analog.powered;
    endproperty
    a_off: assert property (p_off) else $error("no power-down after conversion");
    property p_on; i_convert_start_n[*6] ##1 $fell(o_busy) |-> o_analog.powered[*3]; endproperty
    a_on: assert property (p_on) else $error("powered down with pin high");
    property p_oe; $rose(o_result_byte_lines_oe) |-> $past(!i_cs_n && !i_rd_n); endproperty
    a_oe: assert property (p_oe) else $error("data driven without read");
    c_end: cover property ($fell(o_busy));
    c_rd: cover property ($rose(o_result_byte_lines_oe));
    c_on: cover property (i_convert_start_n[*6] ##1 $fell(o_busy));
endmodule : sapd_ctrl_chk
bind sapd_ctrl sapd_ctrl_chk i_sapd_ctrl_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_convert_start_n(i_convert_start_n), .i_comp_balanced(i_comp_balanced), .i_cs_n(i_cs_n),
    .i_rd_n(i_rd_n), .o_busy(o_busy), .o_analog(o_analog),
    .o_result_byte_lines_oe(o_result_byte_lines_oe));

// >>> testbench/sapd_core_model.sv
`timescale 1ns/100ps
module sapd_core_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire sapd_pkg::sapd_analog_t i_analog,
    input wire logic [9:0] i_code,
    input wire logic [7:0] i_delay,
    output logic o_balanced,
    output logic [9:0] o_code
);
    logic [7:0] cnt;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) cnt <= 8'h00;
        else if (!i_analog.input_select_switch) cnt <= 8'h00;
        else if (cnt != 8'hff) cnt <= cnt + 8'h01;
    end
    // delay 0 never balances, so only the timeout can end it
    assign o_balanced = i_delay != 8'h00 && cnt >= i_delay;
    // outside hold the code is scrambled, not the last value
    assign o_code = i_analog.input_select_switch ? i_code : ~i_code;
endmodule : sapd_core_model

// >>> testbench/sapd_ctrl_tb.sv
`timescale 1ns/100ps
module sapd_ctrl_tb;
    typedef struct packed {
        logic [9:0] code;
        logic [7:0] dly;
        logic [7:0] msb;
        logic [7:0] lsb;
    } sapd_row_t;
    // code, balance delay, expected first byte, expected second byte
    sapd_row_t rows [4] = '{
        '{10'h000, 8'h03, 8'h00, 8'h00},
        '{10'h3ff, 8'h00, 8'hff, 8'hc0},
        '{10'h2a5, 8'h0a, 8'ha9, 8'h40},
        '{10'h15a, 8'h01, 8'h56, 8'h80}
    };
    logic clk = 1'b0, rst_n = 1'b0, cst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1;
    logic busy, bal, oe;
    logic [9:0] code = 10'h000, sar;
    logic [7:0] dly = 8'h03, db;
    sapd_pkg::sapd_analog_t an;
    int mismatches = 0, n_compared = 0, cyc = 0, n;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            conclude();
        end
    end
    sapd_ctrl i_sapd_ctrl (.i_core_clk(clk), .i_rst_n(rst_n), .i_convert_start_n(cst_n),
        .i_comp_balanced(bal), .i_sar_code(sar), .i_cs_n(cs_n), .i_rd_n(rd_n), .o_busy(busy),
        .o_analog(an), .o_result_byte_lines(db), .o_result_byte_lines_oe(oe));
    sapd_core_model i_sapd_core_model (.i_core_clk(clk), .i_rst_n(rst_n), .i_analog(an),
        .i_code(code), .i_delay(dly), .o_balanced(bal), .o_code(sar));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wait_busy(input logic v);
        n = 0;
        while (busy !== v && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(busy, v);
    endtask : wait_busy
    task rd(input logic [7:0] exp);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(oe, 1'b1);
        chk(db, exp);
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask : rd
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(an, 3'b010);
        repeat (40) @(negedge clk);
        chk(busy, 1'b0);
        foreach (rows[i]) begin
            code = rows[i].code;
            dly = rows[i].dly;
            // short pulse keeps average power low
            cst_n = 1'b1;
            repeat (3) @(negedge clk);
            cst_n = 1'b0;
            wait_busy(1'b1);
            n = 0;
            while (busy === 1'b1 && n < 100) begin
                @(negedge clk);
                n++;
            end
            chk(n <= (dly == 8'h00 ? 47 : dly + 4), 1'b1);
            chk(n >= (dly == 8'h00 ? 44 : 1), 1'b1);
            wait_busy(1'b0);
            repeat (4) @(negedge clk);
            chk(an.powered, 1'b0);
            rd(rows[i].msb);
            rd(rows[i].lsb);
        end
        // full-length conversions, so the pin is seen well before each end
        dly = 8'h00;
        cst_n = 1'b1;
        repeat (45) @(negedge clk);
        chk(busy, 1'b0);
        cst_n = 1'b0;
        wait_busy(1'b1);
        cst_n = 1'b1;
        wait_busy(1'b0);
        repeat (40) @(negedge clk);
        chk(an.powered, 1'b1);
        cst_n = 1'b0;
        repeat (8) @(negedge clk);
        chk(busy, 1'b1);
        wait_busy(1'b0);
        repeat (4) @(negedge clk);
        chk(an.powered, 1'b0);
        rd(code[9:2]);
        code = 10'h0c3;
        cst_n = 1'b1;
        repeat (3) @(negedge clk);
        cst_n = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(code[9:2]);
        conclude();
    end
endmodule : sapd_ctrl_tb
